// file: src/asr_pkg.sv
// Purpose: constants and types for the async SRAM host controller
// Assumes: 10 MHz sys_clk, one cycle is 100 ns
// Notes:   timing counts derive from ns figures and the clock period
package asr_pkg;
  localparam int ADDR_W = 14;                        // 16K words
  localparam int DATA_W = 4;                         // 4-bit words
  localparam int CLK_PERIOD_NS = 100;
  localparam int DATA_SETUP_NS = 10;                 // Least data set-up
  localparam int SETUP_CYC_I =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_CYC_I < 1) ? 1 : SETUP_CYC_I;
  localparam int READ_NS = 25;                       // Slowest access time
  localparam int READ_CYC_I = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (READ_CYC_I < 1) ? 1 : READ_CYC_I;
  localparam logic [3:0] CNT_SETUP = 4'(SETUP_CYC);
  localparam logic [3:0] CNT_READ = 4'(READ_CYC);
  localparam logic [3:0] CNT_SYNC = 4'h2;            // Data pin sync flops
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  typedef enum logic [2:0] {
    ASR_IDLE   = 3'b000,
    ASR_WSETUP = 3'b001,
    ASR_WSTROB = 3'b010,
    ASR_WEND   = 3'b011,
    ASR_RSEL   = 3'b100,
    ASR_RWAIT  = 3'b101,
    ASR_REND   = 3'b110
  } asr_state_e;
endpackage : asr_pkg

// file: src/asr_pins_if.sv
// Purpose: pin group between the sequencer and the pin stage
// Assumes: all signals on sys_clk
// Notes:   strobes active low
`timescale 1ns/1ps
`default_nettype none
interface asr_pins_if;
  logic [13:0] addr;
  logic        sel_n;
  logic        wstb_n;
  logic        ogate_n;
  logic [3:0]  wdata;
  logic        drive;
  logic [3:0]  rdata;
  modport seq (output addr, sel_n, wstb_n, ogate_n, wdata, drive,
               input rdata);
  modport pin (input addr, sel_n, wstb_n, ogate_n, wdata, drive,
               output rdata);
endinterface : asr_pins_if
`default_nettype wire

// file: src/asr_pin_stage.sv
// Purpose: data pin stage with a two-flop input synchroniser
// Assumes: data pins arrive asynchronously
// Notes:   first sync flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module asr_pin_stage
  import asr_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [DATA_W-1:0] pin_in,
  asr_pins_if.pin               p
);
  typedef struct packed {
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
  } asr_sync_s;
  asr_sync_s r;
  asr_sync_s next_r;

  // Two-stage capture of data pins
  always_comb begin
    next_r    = r;
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign p.rdata = r.s2;
endmodule : asr_pin_stage
`default_nettype wire

// file: src/asr_host.sv
// Purpose: host controller driving a 16K x 4 asynchronous SRAM
// Assumes: 10 MHz sys_clk, strobes from flip-flops
// Notes:   one request at a time, req_ready shows idle
//          write ends on the strobe, select follows a cycle later
//          read data is taken after the two-flop capture
// Overview of operation
// - The host starts a write by holding select and write strobe low.
// - Write data is set up 10 ns before the ending edge and held after.
// - The host keeps write strobe high throughout a read.
// - The address is valid no later than select falling for a read.
`timescale 1ns/1ps
`default_nettype none
module asr_host
  import asr_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,

  // Request side, taken while req_ready is high
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,

  // Read answer, a one-cycle pulse with held data
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,

  // SRAM address and active low strobes
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_sel_n,
  output logic                   mem_wstb_n,
  output logic                   mem_ogate_n,

  // Shared data pins, split into out, enable and in
  output logic [DATA_W-1:0]      mem_dq_o,
  output logic                   mem_dq_oe,
  input  wire logic [DATA_W-1:0] mem_dq_i
);
  // Whole sequencer state, one register
  typedef struct packed {
    asr_state_e        st;
    logic [3:0]        cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              sel_n;
    logic              wstb_n;
    logic              ogate_n;
    logic              drive;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
  } asr_ctl_s;

  // State register, its next value and the pin group
  asr_ctl_s r;
  asr_ctl_s next_r;
  asr_pins_if pins ();

  // Count decrement shared by all wait states
  // Saturates at zero so a stray zero never wraps
  function automatic logic [3:0] dec(input logic [3:0] v);
    return (v == 4'h0) ? 4'h0 : 4'(v - 4'h1);
  endfunction : dec

  // Two-flop capture of the data pins before any logic
  asr_pin_stage u_pin (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (mem_dq_i),
    .p       (pins.pin)
  );

  // Registered levels into the pin group
  assign pins.addr    = r.addr;
  assign pins.sel_n   = r.sel_n;
  assign pins.wstb_n  = r.wstb_n;
  assign pins.ogate_n = r.ogate_n;
  assign pins.wdata   = r.wdata;
  assign pins.drive   = r.drive;

  // Write: IDLE latches address and data and starts driving,
  //   WSETUP lowers select and write strobe together,
  //   WSTROB raises the write strobe first to end the write,
  //   WEND raises select and releases the data pins.
  // Read: IDLE latches the address, RSEL lowers select and gate,
  //   RWAIT waits out the access time and the two sync flops,
  //   REND raises select and gate together.
  // A whole cycle per state: slow, but write strobe and select never rise in the same cycle.
  // Sequencer; write strobe and select rise a whole cycle apart at write end
  always_comb begin
    next_r        = r;
    // Answer pulse lasts one cycle
    next_r.rvalid = 1'b0;

    case (r.st)
      // Parked, waiting for a request
      ASR_IDLE: begin
        next_r.sel_n   = 1'b1;
        next_r.wstb_n  = 1'b1;
        next_r.ogate_n = 1'b1;
        next_r.drive   = 1'b0;
        // Take a request only from idle
        if (req_valid) begin
          next_r.addr  = req_addr; // Address settles a cycle ahead
          next_r.wdata = req_wdata;
          if (req_write) begin
            // Gate high so host may drive
            next_r.drive = 1'b1;
            next_r.cnt   = CNT_SETUP;
            next_r.st    = ASR_WSETUP;
          end else begin
            // Read: select waits a cycle for the address
            next_r.st = ASR_RSEL;
          end
        end
      end

      // Data already on the pins, open the write
      ASR_WSETUP: begin
        next_r.sel_n  = 1'b0;
        next_r.wstb_n = 1'b0;
        next_r.st     = ASR_WSTROB;
      end

      // Write window, one cycle long
      ASR_WSTROB: begin
        // Data stable well past 10 ns set-up
        next_r.cnt = dec(r.cnt);
        if (r.cnt <= 4'h1) begin
          next_r.wstb_n = 1'b1;
          next_r.st     = ASR_WEND;
        end
      end

      // Write over, deselect and let go of the pins
      ASR_WEND: begin
        // Select rises a cycle later
        // Data held one cycle past write end, then released
        next_r.sel_n = 1'b1;
        next_r.drive = 1'b0;
        next_r.st    = ASR_IDLE;
      end

      // Address stable, select the part for a read
      ASR_RSEL: begin
        next_r.sel_n   = 1'b0;
        next_r.wstb_n  = 1'b1;
        // Gate opens with select; no write in flight
        next_r.ogate_n = 1'b0;
        next_r.cnt     = CNT_READ + CNT_SYNC; // Covers the two sync flops
        next_r.st      = ASR_RWAIT;
      end

      // Access time plus capture delay
      ASR_RWAIT: begin
        next_r.cnt = dec(r.cnt);
        // Sample the captured data on the last count
        if (r.cnt <= 4'h1) begin
          next_r.rdata  = pins.rdata;
          next_r.rvalid = 1'b1;
          next_r.st     = ASR_REND;
        end
      end

      // Read over, deselect and close the gate
      ASR_REND: begin
        next_r.sel_n   = 1'b1;
        next_r.ogate_n = 1'b1;
        next_r.st      = ASR_IDLE;
      end

      // Recover an illegal code to idle
      default: begin
        next_r.st = ASR_IDLE;
      end
    endcase
  end

  // Sync reset parks the pins deselected
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r         <= '0;
      r.st      <= ASR_IDLE;
      r.addr    <= ADDR_RST;
      r.wdata   <= DATA_RST;
      r.rdata   <= DATA_RST;
      r.sel_n   <= 1'b1;
      r.wstb_n  <= 1'b1;
      r.ogate_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Ready decoded from the state register; answers straight from flip-flops
  assign req_ready   = (r.st == ASR_IDLE);
  assign rsp_valid   = r.rvalid;
  assign rsp_rdata   = r.rdata;

  // SRAM pins, registered so no strobe glitches
  assign mem_addr    = pins.addr;
  assign mem_sel_n   = pins.sel_n;
  assign mem_wstb_n  = pins.wstb_n;
  assign mem_ogate_n = pins.ogate_n;
  assign mem_dq_o    = pins.wdata;
  assign mem_dq_oe   = pins.drive;
endmodule : asr_host
`default_nettype wire

// file: verification/asr_sram_mdl.sv
// Purpose: behavioural 16K x 4 async SRAM on the host pins
// Assumes: host drives dq only with mem_dq_oe high
// Notes:   a floating bus shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module asr_sram_mdl
  import asr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              sel_n,
  input  wire logic              wstb_n,
  input  wire logic              ogate_n,
  input  wire logic [DATA_W-1:0] hdq,
  input  wire logic              hoe,
  output logic      [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last = 4'h0;
  // drive only in a gated read
  wire logic rd = !sel_n && wstb_n && !ogate_n;
  // store only while both strobes are low
  always @* if (!sel_n && !wstb_n) mem[addr] = dq;
  // Remember the level so a released bus never looks valid
  always @* if (rd || hoe) last = dq;
  assign dq = hoe ? hdq : (rd ? mem[addr] : ~last);
endmodule : asr_sram_mdl
`default_nettype wire

// file: verification/asr_host_chk.sv
// Purpose: pin sequence checks for the SRAM host
// Assumes: one clock, sync reset
// Notes:   bound into every asr_host
`timescale 1ns/1ps
`default_nettype none
module asr_host_chk
  import asr_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_sel_n,
  input wire logic              mem_wstb_n,
  input wire logic              mem_ogate_n,
  input wire logic [DATA_W-1:0] mem_dq_o,
  input wire logic              mem_dq_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic tw = req_valid && req_ready && req_write;
  wire logic tr = req_valid && req_ready && !req_write;
  chk_write_walk: assert property (tw |=> mem_dq_oe && mem_sel_n ##1
    !mem_wstb_n ##1 mem_wstb_n && !mem_sel_n ##1 mem_sel_n && req_ready)
    else $error("write strobe walk wrong");
  chk_read_answer: assert property (tr |-> !rsp_valid [*5] ##1 rsp_valid)
    else $error("read answer late or early");
  chk_data_setup: assert property ($rose(mem_wstb_n) |->
    $stable(mem_dq_o) && mem_dq_oe) else $error("write data moved");
  chk_addr_first: assert property ($fell(mem_sel_n) |->
    $stable(mem_addr)) else $error("address moved at select");
  chk_write_overlap: assert property (!mem_wstb_n |->
    !mem_sel_n && mem_dq_oe) else $error("strobe without select");
  chk_read_quiet: assert property (!mem_ogate_n |-> mem_wstb_n)
    else $error("write strobe in read");
  chk_gate_off: assert property (mem_dq_oe |-> mem_ogate_n)
    else $error("gate on while driving");
  chk_end_apart: assert property ($rose(mem_sel_n) |-> $past(mem_wstb_n))
    else $error("select rose with strobe");
  chk_idle_desel: assert property (req_ready |-> mem_sel_n)
    else $error("selected while idle");
  cov_write: cover property (tw);
  cov_read: cover property (tr);
  cov_answer: cover property (rsp_valid);
endmodule : asr_host_chk
bind asr_host asr_host_chk i_chk (.*);
`default_nettype wire

// file: verification/asr_host_tb.sv
// Purpose: self-checking bench for asr_host
// Assumes: SRAM model on the pins
// Notes:   reads are checked from a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module asr_host_tb
  import asr_pkg::*;
;
  logic              sys_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_dq_o, mem_dq_i;
  logic              req_ready, rsp_valid, mem_sel_n, mem_wstb_n;
  logic              mem_ogate_n, mem_dq_oe;
  logic [DATA_W-1:0] shadow [int], exp_q [$];
  int                fail_count = 0, comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  asr_host i_dut (.*);
  asr_sram_mdl i_mem (.addr(mem_addr), .sel_n(mem_sel_n), .wstb_n(mem_wstb_n),
    .ogate_n(mem_ogate_n), .hdq(mem_dq_o), .hoe(mem_dq_oe), .dq(mem_dq_i));
  task automatic check(input string what, input logic [DATA_W-1:0] e, s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // Wait for idle at a falling edge, then hold the request
  task automatic req(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge sys_clk);
    end
    if (req_ready !== 1'b1) begin
      fail_count++;
      $display("ERROR req_ready expected 1 seen %b", req_ready);
    end
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    if (w) shadow[a] = d;
    else exp_q.push_back(shadow[a]);
    @(posedge sys_clk);
  endtask : req
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Oldest note against each answer; none left means X
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1)
      check("rsp_rdata", exp_q.size() ? exp_q.pop_front() : 4'hX, rsp_rdata);
  end
  initial begin
    logic [ADDR_W-1:0] a [12];
    void'($urandom(39));
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    // Array ends, word 0 overwritten after the 3FFF write, then reads
    req(1'b1, 14'h0000, 4'hA);
    req(1'b1, 14'h3FFF, 4'h5);
    req(1'b1, 14'h0000, 4'h3);
    req(1'b0, 14'h3FFF, 4'hF);
    req(1'b0, 14'h0000, 4'hF);
    $display("test edges done");
    // Random words out and back
    for (int i = 0; i < 12; i++) begin
      a[i] = ADDR_W'($urandom);
      req(1'b1, a[i], DATA_W'($urandom));
    end
    for (int i = 0; i < 12; i++) req(1'b0, a[i], DATA_W'($urandom));
    @(negedge sys_clk);
    req_valid = 1'b0;
    repeat (12) @(negedge sys_clk);
    check("reads left", 4'h0, DATA_W'(exp_q.size()));
    $display("test random done");
    print_verdict();
  end
  // Watchdog at 4000 cycles, far beyond the fewer than 200 cycles needed
  initial begin
    #400000;
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    print_verdict();
  end
endmodule : asr_host_tb
`default_nettype wire
